// ==== sgps_cfg.svh ====
// Constants of the setting group priority selector
`ifndef SGPS_CFG_SVH
`define SGPS_CFG_SVH
`define SGPS_MAX_GROUPS 8
`define SGPS_IDX_W 3
`define SGPS_SEL_W 4
`define SGPS_SEL_NONE 4'h0
`define SGPS_ACTIVE_RST 3'h0
`define SGPS_USED_RST 3'h0
`define SGPS_OVR_RST 1'b0
`define SGPS_SYNC_STAGES 2
`endif

// ==== sgps_pkg.sv ====
// Types of the setting group priority selector
package sgps_pkg;
  typedef enum logic [1:0] {
    SGPS_IDLE = 2'b00,
    SGPS_AUTO = 2'b01,
    SGPS_FORCED = 2'b10
  } sgps_mode_t;
endpackage : sgps_pkg

// ==== sgps_req_sync.sv ====
// Request input synchroniser with rising edge detection
`timescale 1ns/1ps
`include "sgps_cfg.svh"
module sgps_req_sync #(
  parameter int WIDTH = `SGPS_MAX_GROUPS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] req_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  initial begin
    if (WIDTH < 1) begin
      $error("sgps_req_sync: WIDTH must be at least 1");
    end
  end

  // Two stages before any logic; only sync_q reads meta_q
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= req_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Level is the held state, rise marks a fresh activation
  assign level_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
endmodule : sgps_req_sync

// ==== sgps_selector.sv ====
// Setting group priority selector: picks the one active parameter set
`timescale 1ns/1ps
`include "sgps_cfg.svh"
module sgps_selector #(
  parameter int NUM_GROUPS = `SGPS_MAX_GROUPS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [`SGPS_MAX_GROUPS-1:0] group_req_in,
  input wire logic override_enable_in,
  input wire logic [`SGPS_SEL_W-1:0] override_switch_in,
  input wire logic [`SGPS_SEL_W-1:0] remote_change_in,
  input wire logic [`SGPS_IDX_W-1:0] used_groups_in,
  output logic [`SGPS_IDX_W-1:0] active_group_out,
  output logic [`SGPS_MAX_GROUPS-1:0] active_onehot_out,
  output logic [`SGPS_MAX_GROUPS-1:0] enabled_mask_out,
  output logic [`SGPS_MAX_GROUPS-1:0] request_seen_out,
  output logic [1:0] mode_out,
  output logic active_change_out,
  output logic fail_not_enabled_out,
  output logic fail_lower_prio_out,
  output logic fail_force_out
);
  localparam int MG = `SGPS_MAX_GROUPS;

  initial begin
    if (NUM_GROUPS < 2 || NUM_GROUPS > MG) begin
      $error("sgps_selector: NUM_GROUPS must lie in 2..8");
    end
  end

  // Enabled mask from the used-groups setting, clipped to NUM_GROUPS
  // Counts above NUM_GROUPS are clipped rather than refused
  function automatic logic [MG-1:0] sgps_used_mask(
    input logic [`SGPS_IDX_W-1:0] used
  );
    logic [MG-1:0] m;
    m = '0;
    for (int i = 0; i < MG; i++) begin
      m[i] = (i <= int'(used)) && (i < NUM_GROUPS);
    end
    return m;
  endfunction : sgps_used_mask

  // Highest priority set bit: {found, index}
  // Downward loop, so the lowest set index is the last to win
  function automatic logic [`SGPS_IDX_W:0] sgps_first(
    input logic [MG-1:0] v
  );
    logic [`SGPS_IDX_W:0] r;
    r = '0;
    for (int i = MG - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, i[`SGPS_IDX_W-1:0]};
      end
    end
    return r;
  endfunction : sgps_first

  // Operator code to group index; code zero means none
  // Codes above eight wrap; callers check the range first
  function automatic logic [`SGPS_IDX_W-1:0] sgps_code_idx(
    input logic [`SGPS_SEL_W-1:0] code
  );
    logic [`SGPS_SEL_W-1:0] t;
    t = code - 4'h1;
    return t[`SGPS_IDX_W-1:0];
  endfunction : sgps_code_idx

  // Operator code names a group inside the enabled set
  // Code zero and codes above eight are never valid
  function automatic logic sgps_code_ok(
    input logic [`SGPS_SEL_W-1:0] code,
    input logic [MG-1:0] en
  );
    logic ok;
    ok = 1'b0;
    if (code != `SGPS_SEL_NONE && code <= 4'h8) begin
      ok = en[sgps_code_idx(code)];
    end
    return ok;
  endfunction : sgps_code_ok

  // Synchronised level and fresh rise of each request pin
  logic [MG-1:0] req_level;
  logic [MG-1:0] req_rise;

  // Request pins come from outside the clock domain
  sgps_req_sync #(
    .WIDTH(MG)
  ) u_req_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .req_in(group_req_in),
    .level_out(req_level),
    .rise_out(req_rise)
  );

  // Active group state and its next value
  logic [`SGPS_IDX_W-1:0] active_q;
  logic [`SGPS_IDX_W-1:0] active_d;

  // Operator history, so a standing choice acts once
  logic [`SGPS_SEL_W-1:0] ovr_sw_prev_q;
  logic [`SGPS_SEL_W-1:0] rem_prev_q;
  logic ovr_prev_q;

  // Status and failure registers
  logic [1:0] mode_q;
  logic change_q;
  logic fail_ne_q;
  logic fail_lp_q;
  logic fail_fc_q;
  logic [MG-1:0] seen_q;

  // Enabled groups and operating mode
  // Override outranks idle, so a single group can still be forced
  wire [MG-1:0] en_mask = sgps_used_mask(used_groups_in);
  wire single_group = (en_mask == 8'h01);
  sgps_pkg::sgps_mode_t mode_w;
  assign mode_w = override_enable_in ? sgps_pkg::SGPS_FORCED :
                  single_group ? sgps_pkg::SGPS_IDLE :
                  sgps_pkg::SGPS_AUTO;

  // Held levels of enabled groups; a level on any enabled group is an activation
  // Disabled groups neither hold nor block anything
  wire [MG-1:0] held = req_level & en_mask;
  wire [MG-1:0] fresh = req_rise;
  logic [MG-1:0] blk;

  // Chain of blocking: a held level masks every lower priority group
  // Seven stages deep at most, short enough for one cycle
  assign blk[0] = 1'b0;
  genvar g;
  generate
    for (g = 1; g < MG; g++) begin : g_blk
      assign blk[g] = blk[g-1] | held[g-1];
    end
  endgenerate
  // Group eight has nothing below it, so its level masks nothing

  // Automatic candidates: fresh pulses and held levels not blocked
  // A pulse above a held level wins only while its synchronised level stays high
  wire [MG-1:0] auto_cand = (fresh | held) & en_mask & ~blk;
  wire [`SGPS_IDX_W:0] auto_pick = sgps_first(auto_cand);
  wire auto_hit = auto_pick[`SGPS_IDX_W];
  wire [`SGPS_IDX_W-1:0] auto_idx = auto_pick[`SGPS_IDX_W-1:0];

  // Automatic failures, counted only when inputs are heeded
  // Held levels report nothing; only fresh rises can fail
  wire auto_heeded = (mode_w == sgps_pkg::SGPS_AUTO);
  wire auto_ne = auto_heeded && |(fresh & ~en_mask);
  wire auto_lp = auto_heeded && |(fresh & en_mask & blk);

  // Forced switch acts once per new choice, like a pulse
  // Enabling override applies the standing switch value once
  wire ovr_new = (override_switch_in != ovr_sw_prev_q) || !ovr_prev_q;
  wire ovr_req = override_enable_in && ovr_new &&
                 (override_switch_in != `SGPS_SEL_NONE);
  wire ovr_ok = ovr_req &&
                sgps_code_ok(override_switch_in, en_mask);
  wire ovr_ne = ovr_req && !ovr_ok;
  wire ovr_refused = !override_enable_in &&
                     (override_switch_in != ovr_sw_prev_q) &&
                     (override_switch_in != `SGPS_SEL_NONE);
  wire [`SGPS_IDX_W-1:0] ovr_idx = sgps_code_idx(override_switch_in);

  // Remote change: needs override, refused under a higher held level
  // The force switch wins when both change in the same cycle
  wire rem_req = (remote_change_in != rem_prev_q) &&
                 (remote_change_in != `SGPS_SEL_NONE);
  wire [`SGPS_IDX_W-1:0] rem_idx = sgps_code_idx(remote_change_in);
  wire rem_en = sgps_code_ok(remote_change_in, en_mask);
  wire rem_gate = rem_req && override_enable_in;
  wire rem_ok = rem_gate && rem_en && !blk[rem_idx];
  wire rem_ne = rem_gate && !rem_en;
  wire rem_lp = rem_gate && rem_en && blk[rem_idx];
  wire rem_refused = rem_req && !override_enable_in;

  // Active group falls back to group one if its group is disabled
  // Shrinking the used count never leaves a disabled group active
  wire active_valid = en_mask[active_q];

  // Next active group, one decision per cycle
  always_comb begin
    active_d = active_q;
    // Idle pins group one; forced mode uses the request pins only to block remote changes
    unique case (mode_w)
      sgps_pkg::SGPS_IDLE: begin
        active_d = `SGPS_ACTIVE_RST;
      end
      sgps_pkg::SGPS_AUTO: begin
        if (auto_hit) begin
          active_d = auto_idx;
        end else if (!active_valid) begin
          active_d = `SGPS_ACTIVE_RST;
        end else begin
          active_d = active_q;
        end
      end
      sgps_pkg::SGPS_FORCED: begin
        if (ovr_ok) begin
          active_d = ovr_idx;
        end else if (rem_ok) begin
          active_d = rem_idx;
        end else if (!active_valid) begin
          active_d = `SGPS_ACTIVE_RST;
        end else begin
          active_d = active_q;
        end
      end
    endcase
  end

  // Active group register; output follows one cycle later
  // Change flag rises with the new value, as a status aid
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_q <= `SGPS_ACTIVE_RST;
      change_q <= 1'b0;
    end else begin
      active_q <= active_d;
      change_q <= (active_d != active_q);
    end
  end

  // Previous operator values, so each choice acts only once
  // Reset to none, so a nonzero choice at start counts as new
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ovr_sw_prev_q <= `SGPS_SEL_NONE;
      rem_prev_q <= `SGPS_SEL_NONE;
      ovr_prev_q <= `SGPS_OVR_RST;
    end else begin
      ovr_sw_prev_q <= override_switch_in;
      rem_prev_q <= remote_change_in;
      ovr_prev_q <= override_enable_in;
    end
  end

  // Failure pulses, one cycle each, aligned with the active output
  // Pulses, not sticky flags, so a set and a clear never collide
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fail_ne_q <= 1'b0;
      fail_lp_q <= 1'b0;
      fail_fc_q <= 1'b0;
    end else begin
      fail_ne_q <= auto_ne | ovr_ne | rem_ne;
      fail_lp_q <= auto_lp | rem_lp;
      fail_fc_q <= ovr_refused | rem_refused;
    end
  end

  // Mode and seen levels are status only
  // Mode lags its inputs and seen the synchronised levels by one cycle, in step with the active output
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q <= sgps_pkg::SGPS_IDLE;
      seen_q <= '0;
    end else begin
      mode_q <= mode_w;
      seen_q <= req_level;
    end
  end

  // One-hot view of the active group; exactly one bit is ever set
  // Decoded from the register, so it cannot glitch
  logic [MG-1:0] onehot;
  generate
    for (g = 0; g < MG; g++) begin : g_onehot
      assign onehot[g] = (int'(active_q) == g);
    end
  endgenerate

  // Outputs come from registers, apart from the enabled mask decode
  assign active_group_out = active_q;
  assign active_onehot_out = onehot;
  assign enabled_mask_out = en_mask;
  assign request_seen_out = seen_q;
  assign mode_out = mode_q;
  assign active_change_out = change_q;
  assign fail_not_enabled_out = fail_ne_q;
  assign fail_lower_prio_out = fail_lp_q;
  assign fail_force_out = fail_fc_q;
endmodule : sgps_selector

// ==== sgps_req_model.sv ====
// Request source model: held levels and short pulses on the pins
`timescale 1ns/1ps
module sgps_req_model (
  input wire logic clk_in,
  input wire logic [7:0] level_in,
  input wire logic [7:0] pulse_in,
  output logic [7:0] req_out
);
  logic [7:0] pulse_q;
  // Stretch pulses to two cycles so the synchroniser never misses one
  always_ff @(posedge clk_in) pulse_q <= pulse_in;
  assign req_out = level_in | pulse_in | pulse_q;
endmodule : sgps_req_model

// ==== sgps_selector_assertions.sv ====
// Checker of the setting group priority selector ports
`timescale 1ns/1ps
module sgps_chk #(
  parameter int NUM_GROUPS = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic override_enable_in,
  input wire logic [3:0] override_switch_in,
  input wire logic [3:0] remote_change_in,
  input wire logic [2:0] used_groups_in,
  input wire logic [2:0] active_group_out,
  input wire logic [7:0] active_onehot_out,
  input wire logic [7:0] enabled_mask_out,
  input wire logic [7:0] request_seen_out,
  input wire logic [1:0] mode_out,
  input wire logic active_change_out,
  input wire logic fail_lower_prio_out,
  input wire logic fail_force_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Forced choice as an index; codes above eight are invalid
  wire [2:0] sw_idx = override_switch_in[2:0] - 3'h1;
  wire sw_ok = override_switch_in != 4'h0 && override_switch_in <= 4'h8;
  // Enabled held levels of higher priority than the active group
  wire [7:0] above = request_seen_out & enabled_mask_out
    & ((8'h01 << active_group_out) - 8'h01);
  property p_hot; active_onehot_out == 8'h01 << active_group_out;
  endproperty
  a_hot: assert property (p_hot) else $error("onehot wrong");
  property p_mask; enabled_mask_out == ((8'hff >> (3'h7 - used_groups_in))
    & ~(8'hff << NUM_GROUPS)); endproperty
  a_mask: assert property (p_mask) else $error("mask wrong");
  property p_idle; used_groups_in == 3'h0 && $past(used_groups_in) == 3'h0
    |-> active_group_out == 3'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle moved");
  // Auto mode: no enabled held level may outrank the active group
  property p_prio; mode_out == 2'b01 && $stable(used_groups_in)
    |-> above == 8'h00; endproperty
  a_prio: assert property (p_prio) else $error("prio broken");
  property p_hold; override_enable_in && $past(override_enable_in)
    && $stable(override_switch_in) && $stable(remote_change_in)
    && $stable(used_groups_in) |=> $stable(active_group_out); endproperty
  a_hold: assert property (p_hold) else $error("forced moved");
  property p_force; override_enable_in && !$stable(override_switch_in)
    && sw_ok && enabled_mask_out[sw_idx]
    |=> active_group_out == $past(sw_idx); endproperty
  a_force: assert property (p_force) else $error("force lost");
  property p_chg; !$stable(active_group_out) |-> active_change_out;
  endproperty
  a_chg: assert property (p_chg) else $error("no change pulse");
  property p_ff; !override_enable_in && !$stable(remote_change_in)
    && remote_change_in != 4'h0 |=> fail_force_out; endproperty
  a_ff: assert property (p_ff) else $error("no force fail");
  c_forced: cover property (mode_out == 2'b10 && active_change_out);
  c_lower: cover property (fail_lower_prio_out);
  c_ff: cover property (fail_force_out);
endmodule : sgps_chk
bind sgps_selector sgps_chk #(.NUM_GROUPS(NUM_GROUPS)) u_chk (.*);

// ==== sgps_tb.sv ====
// Testbench of the setting group priority selector
`timescale 1ns/1ps
module tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ovr = 1'b0;
  logic [3:0] sw = 4'h0;
  logic [3:0] rem = 4'h0;
  logic [2:0] used = 3'h0;
  logic [7:0] lvl = 8'h00;
  logic [7:0] pls = 8'h00;
  logic [7:0] req;
  logic [2:0] act;
  logic [2:0] seen = 3'h0;
  logic ne, lp, ff;
  logic [1:0] mode;
  logic clr = 1'b0;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #2 clk_in = ~clk_in;
  sgps_req_model u_sgps_req_model (.clk_in(clk_in), .level_in(lvl),
    .pulse_in(pls), .req_out(req));
  sgps_selector u_sgps_selector (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .group_req_in(req), .override_enable_in(ovr),
    .override_switch_in(sw), .remote_change_in(rem),
    .used_groups_in(used), .active_group_out(act),
    .active_onehot_out(), .enabled_mask_out(), .request_seen_out(),
    .mode_out(mode), .active_change_out(), .fail_not_enabled_out(ne),
    .fail_lower_prio_out(lp), .fail_force_out(ff));
  // Fail flags are one-cycle pulses, so gather them between checks
  always @(posedge clk_in) begin
    seen <= clr ? 3'h0 : (seen | {ne, lp, ff});
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic go(input int n);
    repeat (n) @(posedge clk_in);
  endtask : go
  task automatic pulse(input logic [7:0] m);
    go(1);
    pls <= m;
    go(1);
    pls <= 8'h00;
  endtask : pulse
  // Operator and level inputs change together at one edge
  task automatic drv(input logic o, input logic [3:0] s, input logic [3:0] r,
      input logic [2:0] u, input logic [7:0] l);
    go(1);
    ovr <= o;
    sw <= s;
    rem <= r;
    used <= u;
    lvl <= l;
  endtask : drv
  task automatic cmp(input logic [2:0] got, input logic [2:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_mode(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_mode
  // Operator choice shows exactly one edge after it is applied
  task automatic lat(input logic [2:0] e0, input logic [2:0] e1);
    #1 cmp(act, e0);
    go(1);
    #1 cmp(act, e1);
  endtask : lat
  // Clear flags, allow sync plus decision time, then look
  task automatic chka(input logic [2:0] e);
    clr <= 1'b1;
    go(1);
    clr <= 1'b0;
    go(5);
    #1 cmp(act, e);
  endtask : chka
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    go(10);
    rst_n_in <= 1'b1;
    chka(3'h0);
    pulse(8'h04);
    chka(3'h0);
    cmp(seen, 3'h0);
    cmp_mode(mode, sgps_pkg::SGPS_IDLE);
    drv(1'b0, 4'h0, 4'h0, 3'h7, 8'h00);
    pulse(8'h04);
    chka(3'h2);
    cmp_mode(mode, sgps_pkg::SGPS_AUTO);
    drv(1'b0, 4'h0, 4'h0, 3'h7, 8'h50);
    chka(3'h4);
    pulse(8'h80);
    chka(3'h4);
    cmp(seen, 3'h2);
    pulse(8'h02);
    chka(3'h4);
    drv(1'b0, 4'h0, 4'h0, 3'h7, 8'h80);
    pulse(8'h20);
    chka(3'h7);
    cmp(seen, 3'h0);
    drv(1'b0, 4'h0, 4'h0, 3'h7, 8'h01);
    pulse(8'h02);
    chka(3'h0);
    cmp(seen, 3'h2);
    drv(1'b0, 4'h0, 4'h0, 3'h2, 8'h00);
    pulse(8'h20);
    chka(3'h0);
    cmp(seen, 3'h4);
    drv(1'b1, 4'h2, 4'h0, 3'h2, 8'h00);
    pulse(8'h01);
    chka(3'h1);
    cmp_mode(mode, sgps_pkg::SGPS_FORCED);
    drv(1'b1, 4'h7, 4'h0, 3'h2, 8'h00);
    chka(3'h1);
    cmp(seen, 3'h4);
    drv(1'b1, 4'h9, 4'h0, 3'h2, 8'h00);
    chka(3'h1);
    cmp(seen, 3'h4);
    drv(1'b1, 4'h7, 4'h3, 3'h2, 8'h00);
    chka(3'h2);
    drv(1'b0, 4'h7, 4'h3, 3'h7, 8'h00);
    chka(3'h2);
    drv(1'b1, 4'h2, 4'h3, 3'h7, 8'h08);
    lat(3'h2, 3'h1);
    chka(3'h1);
    drv(1'b0, 4'h2, 4'h3, 3'h7, 8'h08);
    chka(3'h3);
    drv(1'b0, 4'h2, 4'h6, 3'h7, 8'h08);
    chka(3'h3);
    cmp(seen, 3'h1);
    drv(1'b1, 4'h2, 4'h6, 3'h7, 8'h08);
    chka(3'h1);
    drv(1'b1, 4'h2, 4'h5, 3'h7, 8'h08);
    chka(3'h1);
    cmp(seen, 3'h2);
    give_verdict();
  end
endmodule : tb
